// ===== cmh_pkg.sv
// Package for the custom memory and hardware-loop decoder.
// Assumes 32-bit instruction words and a 32-bit program counter.
package cmh_pkg;
  // ====================================================================
  // Opcodes and function fields
  localparam logic [6:0] OPC_LOAD_PI   = 7'h0B;
  localparam logic [6:0] OPC_CUSTOM    = 7'h2B;
  localparam logic [2:0] F3_LB         = 3'h0;
  localparam logic [2:0] F3_LH         = 3'h1;
  localparam logic [2:0] F3_LW         = 3'h2;
  localparam logic [2:0] F3_REG        = 3'h3;
  localparam logic [2:0] F3_LBU        = 3'h4;
  localparam logic [2:0] F3_LHU        = 3'h5;
  localparam logic [2:0] F3_EVT        = 3'h3;
  localparam logic [2:0] F3_HWLP       = 3'h4;
  localparam logic [6:0] F7_LB_PI      = 7'h00;
  localparam logic [6:0] F7_LBU_PI     = 7'h08;
  localparam logic [6:0] F7_LH_PI      = 7'h01;
  localparam logic [6:0] F7_LHU_PI     = 7'h09;
  localparam logic [6:0] F7_LW_PI      = 7'h02;
  localparam logic [6:0] F7_RR_FLAG    = 7'h04;
  localparam logic [6:0] F7_SB_PI      = 7'h10;
  localparam logic [6:0] F7_SH_PI      = 7'h11;
  localparam logic [6:0] F7_SW_PI      = 7'h12;
  localparam logic [6:0] F7_SB_RR      = 7'h14;
  localparam logic [6:0] F7_SH_RR      = 7'h15;
  localparam logic [6:0] F7_SW_RR      = 7'h16;
  // ====================================================================
  // Loop operation selector values
  localparam logic [3:0] LOOP_START_IMM = 4'h0;
  localparam logic [3:0] LOOP_START_REG = 4'h1;
  localparam logic [3:0] LOOP_END_IMM   = 4'h2;
  localparam logic [3:0] LOOP_END_REG   = 4'h3;
  localparam logic [3:0] LOOP_COUNT_IMM = 4'h4;
  localparam logic [3:0] LOOP_COUNT_REG = 4'h5;
  localparam logic [3:0] LOOP_SHORT_IMM = 4'h6;
  localparam logic [3:0] LOOP_SHORT_REG = 4'h7;
  localparam logic [31:0] PC_STEP       = 32'h0000_0004;
  localparam int          NUM_LOOPS     = 2;
  // ====================================================================
  // Access sizes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
endpackage

// ===== cmh_loop_regs.sv
// Two hardware loop register sets, written by decoded setup pulses.
// Assumes the decoder gives one write strobe per field per cycle.
`timescale 1ns/1ps
module cmh_loop_regs
  import cmh_pkg::*;
(
  // Clock and reset
  input  wire logic                 ref_clk_in,
  input  wire logic                 rstn_in,
  // Write port
  input  wire logic                 sel_in,
  input  wire logic                 we_start_in,
  input  wire logic                 we_end_in,
  input  wire logic                 we_count_in,
  input  wire logic [31:0]          start_in,
  input  wire logic [31:0]          end_in,
  input  wire logic [31:0]          count_in,
  // Loop state
  output logic [NUM_LOOPS*32-1:0]   start_out,
  output logic [NUM_LOOPS*32-1:0]   end_out,
  output logic [NUM_LOOPS*32-1:0]   count_out
);
  // ====================================================================
  // One independent set per loop
  genvar g;
  generate
    for (g = 0; g < NUM_LOOPS; g++) begin : g_loop
      wire hit = (sel_in == 1'(g));
      always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          start_out[g*32 +: 32] <= RESET_WORD;
          end_out[g*32 +: 32]   <= RESET_WORD;
          count_out[g*32 +: 32] <= RESET_WORD;
        end else begin
          if (hit && we_start_in) start_out[g*32 +: 32] <= start_in;
          if (hit && we_end_in)   end_out[g*32 +: 32]   <= end_in;
          if (hit && we_count_in) count_out[g*32 +: 32] <= count_in;
        end
      end
    end
  endgenerate
endmodule

// ===== cmh_decoder.sv
// Decoder for custom post-increment memory, event load and loop setup.
// Assumes fetch presents one instruction with its pc and register values.
// Overview of operation
// - Opcode 0B funct3 picks post-increment immediate load size
// - Register-offset post-increment loads from five funct7 codes
// - Register-plus-register loads, base left unchanged
// - Immediate post-increment stores with split offset
// - Register-offset post-increment stores, offset in 11:7
// - Register-plus-register stores, no base writeback
// - Event load only when cluster support enabled
// - Event load is opcode 0B funct3 011
// - Loop instructions only when extension enabled
// - Long setup sets start, end or count
// - Funct3 100, selector in 11:8, bit 7 loop
// - Fixed zero fields in long setup forms
// - Two independent loops chosen by bit 7
// - Post-increment uses old base, writes base+offset
// - Signed loads sign-extend, unsigned zero-extend
`timescale 1ns/1ps
module cmh_decoder
  import cmh_pkg::*;
#(
  parameter bit CUSTOM_EXT_ENABLE_PARAM = 1'b1,
  parameter bit CLUSTER_SUPPORT_PARAM   = 1'b0
)(
  // Clock and reset
  input  wire logic                           ref_clk_in,
  input  wire logic                           rstn_in,
  // Instruction from fetch
  input  wire logic                           instr_valid_in,
  input  wire logic [31:0]                    instr_in,
  input  wire logic [31:0]                    pc_in,
  input  wire logic [31:0]                    rs1_data_in,
  input  wire logic [31:0]                    rs2_data_in,
  input  wire logic [31:0]                    rs3_data_in,
  // Load data return
  input  wire logic [31:0]                    mem_rdata_in,
  // Memory control
  output logic                                mem_req_out,
  output logic                                mem_we_out,
  output logic [1:0]                          mem_size_out,
  output logic                                mem_signed_out,
  output logic [31:0]                         mem_addr_out,
  output logic [31:0]                         mem_wdata_out,
  output logic                                event_sleep_out,
  // Register file control
  output logic                                rd_we_out,
  output logic [4:0]                          rd_addr_out,
  output logic                                base_we_out,
  output logic [4:0]                          base_addr_out,
  output logic [31:0]                         base_wdata_out,
  output logic [31:0]                         load_ext_out,
  output logic                                illegal_out,
  // Loop state
  output logic [cmh_pkg::NUM_LOOPS*32-1:0]    loop_start_out,
  output logic [cmh_pkg::NUM_LOOPS*32-1:0]    loop_end_out,
  output logic [cmh_pkg::NUM_LOOPS*32-1:0]    loop_count_out
);
  import cmh_pkg::*;
  // ====================================================================
  // Fields
  wire [6:0]  opc   = instr_in[6:0];
  wire [2:0]  f3    = instr_in[14:12];
  wire [6:0]  f7    = instr_in[31:25];
  wire [3:0]  loop_op_select = instr_in[11:8];
  wire [31:0] imm_i = {{20{instr_in[31]}}, instr_in[31:20]};
  wire [31:0] imm_s = {{20{instr_in[31]}}, instr_in[31:25], instr_in[11:7]};
  wire [31:0] loop_unsigned_imm    = {20'h00000, instr_in[31:20]};
  wire [31:0] short_end_offset_imm = {27'h0000000, instr_in[19:15]};
  wire        zero_hi  = (instr_in[31:20] == 12'h000);
  wire        zero_rs1 = (instr_in[19:15] == 5'h00);

  function automatic logic [1:0] f7_size(input logic [6:0] f);
    f7_size = f[1:0];
  endfunction

  // ====================================================================
  // Class decode
  wire is_ldpi_op  = instr_valid_in && opc == OPC_LOAD_PI;
  wire is_cust_op  = instr_valid_in && opc == OPC_CUSTOM;
  wire ld_imm = CUSTOM_EXT_ENABLE_PARAM && is_ldpi_op && (f3 == F3_LB || f3 == F3_LBU
                || f3 == F3_LH || f3 == F3_LHU || f3 == F3_LW);
  wire event_word_load = CLUSTER_SUPPORT_PARAM && is_ldpi_op && f3 == F3_EVT;
  wire f7_load = (f7 == F7_LB_PI || f7 == F7_LBU_PI || f7 == F7_LH_PI
                  || f7 == F7_LHU_PI || f7 == F7_LW_PI);
  wire f7_rr   = (f7 == (F7_LB_PI | F7_RR_FLAG) || f7 == (F7_LBU_PI | F7_RR_FLAG)
                  || f7 == (F7_LH_PI | F7_RR_FLAG) || f7 == (F7_LHU_PI | F7_RR_FLAG)
                  || f7 == (F7_LW_PI | F7_RR_FLAG));
  wire reg_op  = CUSTOM_EXT_ENABLE_PARAM && is_cust_op && f3 == F3_REG;
  wire ld_pi_r = reg_op && f7_load;
  wire ld_rr   = reg_op && f7_rr;
  wire st_imm  = CUSTOM_EXT_ENABLE_PARAM && is_cust_op
                 && (f3 == F3_LB || f3 == F3_LH || f3 == F3_LW);
  wire st_pi_r = reg_op && (f7 == F7_SB_PI || f7 == F7_SH_PI || f7 == F7_SW_PI);
  wire st_rr   = reg_op && (f7 == F7_SB_RR || f7 == F7_SH_RR || f7 == F7_SW_RR);
  wire hw_op   = CUSTOM_EXT_ENABLE_PARAM && is_cust_op && f3 == F3_HWLP;
  wire loop_form_ok =
      ((loop_op_select == LOOP_START_IMM || loop_op_select == LOOP_END_IMM
        || loop_op_select == LOOP_COUNT_IMM) && zero_rs1)
   || ((loop_op_select == LOOP_START_REG || loop_op_select == LOOP_END_REG
        || loop_op_select == LOOP_COUNT_REG) && zero_hi)
   || loop_op_select == LOOP_SHORT_IMM || loop_op_select == LOOP_SHORT_REG;
  wire loop_ok = hw_op && loop_form_ok;
  wire any_load  = ld_imm || ld_pi_r || ld_rr || event_word_load;
  wire any_store = st_imm || st_pi_r || st_rr;
  wire post_inc  = ld_imm || ld_pi_r || st_imm || st_pi_r;
  wire is_custom = is_ldpi_op || is_cust_op;
  // Bit-manipulation encodings share opcode 2B funct3 011; left to the ALU decoder
  wire alu_shared = is_cust_op && f3 == F3_REG && !f7_load && !f7_rr
                    && !st_pi_r && !st_rr && CUSTOM_EXT_ENABLE_PARAM;
  wire next_illegal = is_custom && !(any_load || any_store || loop_ok || alu_shared);

  // ====================================================================
  // Address, size and writeback
  // Stores take their offset register from 11:7, loads from 24:20
  wire [31:0] offset = ld_imm ? imm_i : st_imm ? imm_s
                     : (st_pi_r || st_rr) ? rs3_data_in : rs2_data_in;
  wire [31:0] sum    = rs1_data_in + offset;
  wire [31:0] next_addr = (ld_rr || st_rr || event_word_load) ?
                          (event_word_load ? rs1_data_in + imm_i : sum) : rs1_data_in;
  wire [1:0]  next_size = ld_imm ? ((f3[1:0] == 2'h2) ? SIZE_WORD : f3[1:0])
                        : (st_imm ? f3[1:0] : (event_word_load ? SIZE_WORD : f7_size(f7)));
  wire        next_signed = ld_imm ? !f3[2] : !f7[3];

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mem_req_out     <= 1'b0;
      mem_we_out      <= 1'b0;
      mem_size_out    <= SIZE_BYTE;
      mem_signed_out  <= 1'b0;
      mem_addr_out    <= RESET_WORD;
      mem_wdata_out   <= RESET_WORD;
      event_sleep_out <= 1'b0;
      rd_we_out       <= 1'b0;
      rd_addr_out     <= 5'h00;
      base_we_out     <= 1'b0;
      base_addr_out   <= 5'h00;
      base_wdata_out  <= RESET_WORD;
      illegal_out     <= 1'b0;
    end else begin
      mem_req_out     <= any_load || any_store;
      mem_we_out      <= any_store;
      mem_size_out    <= next_size;
      mem_signed_out  <= next_signed && !event_word_load;
      mem_addr_out    <= next_addr;
      mem_wdata_out   <= rs2_data_in;
      event_sleep_out <= event_word_load;
      rd_we_out       <= any_load;
      rd_addr_out     <= instr_in[11:7];
      base_we_out     <= post_inc;
      base_addr_out   <= instr_in[19:15];
      base_wdata_out  <= sum;
      illegal_out     <= next_illegal;
    end
  end

  // ====================================================================
  // Load extension; combinational on returned data
  wire [31:0] ld_byte = {{24{mem_signed_out & mem_rdata_in[7]}}, mem_rdata_in[7:0]};
  wire [31:0] ld_half = {{16{mem_signed_out & mem_rdata_in[15]}}, mem_rdata_in[15:0]};
  assign load_ext_out = (mem_size_out == SIZE_BYTE) ? ld_byte :
                        (mem_size_out == SIZE_HALF) ? ld_half : mem_rdata_in;

  // ====================================================================
  // Loop setup values
  wire [31:0] pc_rel_l = pc_in + {loop_unsigned_imm[29:0], 2'b00};
  wire [31:0] pc_rel_s = pc_in + {short_end_offset_imm[29:0], 2'b00};
  wire is_short  = loop_op_select == LOOP_SHORT_IMM || loop_op_select == LOOP_SHORT_REG;
  wire we_start  = loop_ok && (loop_op_select == LOOP_START_IMM
                   || loop_op_select == LOOP_START_REG || is_short);
  wire we_end    = loop_ok && (loop_op_select == LOOP_END_IMM
                   || loop_op_select == LOOP_END_REG || is_short);
  wire we_count  = loop_ok && (loop_op_select == LOOP_COUNT_IMM
                   || loop_op_select == LOOP_COUNT_REG || is_short);
  wire [31:0] start_val = is_short ? pc_in + PC_STEP
                        : (loop_op_select[0] ? rs1_data_in : pc_rel_l);
  wire [31:0] end_val   = (loop_op_select == LOOP_SHORT_IMM) ? pc_rel_s
                        : (is_short || !loop_op_select[0]) ? pc_rel_l : rs1_data_in;
  wire [31:0] count_val = (loop_op_select == LOOP_SHORT_IMM) ? loop_unsigned_imm
                        : (loop_op_select[0] ? rs1_data_in : loop_unsigned_imm);

  cmh_loop_regs u_loops (
    .ref_clk_in  (ref_clk_in),
    .rstn_in     (rstn_in),
    .sel_in      (instr_in[7]),
    .we_start_in (we_start),
    .we_end_in   (we_end),
    .we_count_in (we_count),
    .start_in    (start_val),
    .end_in      (end_val),
    .count_in    (count_val),
    .start_out   (loop_start_out),
    .end_out     (loop_end_out),
    .count_out   (loop_count_out)
  );

  // ====================================================================
  // Checks
  illegal_flag_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (is_ldpi_op && (f3[2:1] == 2'h3 || (f3 == F3_EVT && !CLUSTER_SUPPORT_PARAM)))
    |=> illegal_out) else $error("unlisted or disabled load not illegal");
  evt_sleep_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    event_sleep_out |-> mem_req_out && !mem_we_out && mem_size_out == SIZE_WORD)
    else $error("event load not a word read");
  evt_addr_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    event_word_load |=> mem_addr_out == $past(rs1_data_in) + $past(imm_i) && !base_we_out)
    else $error("event load address wrong");
  pi_addr_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    post_inc |=> mem_addr_out == $past(rs1_data_in) && base_we_out
    && base_wdata_out == $past(sum)) else $error("post increment wrong");
  rr_nowb_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (ld_rr || st_rr) |=> !base_we_out && mem_req_out)
    else $error("reg-reg wrote base");
  st_rr_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    st_rr |=> mem_we_out && mem_addr_out == $past(rs1_data_in) + $past(rs3_data_in))
    else $error("reg-reg store address wrong");
  st_imm_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    st_imm |=> mem_we_out && base_wdata_out == $past(rs1_data_in) + $past(imm_s))
    else $error("immediate store offset wrong");
  ld_size_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (ld_imm && f3 == F3_LHU) |=> mem_size_out == SIZE_HALF && !mem_signed_out)
    else $error("load size wrong");
  ld_pir_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (ld_pi_r && f7 == F7_LBU_PI) |=> mem_size_out == SIZE_BYTE && !mem_signed_out
    && base_we_out) else $error("reg offset load wrong");
  st_pir_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    st_pi_r |=> base_wdata_out == $past(rs1_data_in) + $past(rs3_data_in))
    else $error("reg offset store wrong");
  ext_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (mem_size_out == SIZE_BYTE && mem_signed_out) |-> load_ext_out[31:8] == {24{mem_rdata_in[7]}})
    else $error("byte sign extension wrong");
  short_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (loop_ok && is_short && !instr_in[7]) |=> loop_start_out[31:0] == $past(pc_in) + PC_STEP)
    else $error("short setup start wrong");
  long_end_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (loop_ok && loop_op_select == LOOP_END_IMM && instr_in[7])
    |=> loop_end_out[63:32] == $past(pc_rel_l)) else $error("end imm wrong");
  iso_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (!(loop_ok && !instr_in[7])) |=> $stable(loop_count_out[31:0]))
    else $error("loop 0 changed by loop 1");
  hw_gate_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (hw_op && !loop_form_ok) |=> illegal_out) else $error("bad loop form legal");
  cov_pi_ld_c: cover property (@(posedge ref_clk_in) ld_imm ##1 base_we_out);
  cov_st_c: cover property (@(posedge ref_clk_in) st_pi_r);
  cov_short_c: cover property (@(posedge ref_clk_in) loop_ok && is_short);
  cov_ill_c: cover property (@(posedge ref_clk_in) illegal_out);
endmodule

// ===== cmh_fetch_model.sv
// Fetch stage model: hands one instruction, its pc and its operands to the decoder.
// Assumes the bench calls its tasks just after a falling clock edge.
`timescale 1ns/1ps
module cmh_fetch_model (
  // Instruction towards the decoder
  output logic        instr_valid_out,
  output logic [31:0] instr_out,
  output logic [31:0] pc_out,
  output logic [31:0] rs1_out,
  output logic [31:0] rs2_out,
  output logic [31:0] rs3_out
);
  // ==================================================================
  // Register file, filled by the bench after seeding
  logic [31:0] regs [32];
  initial begin
    {instr_valid_out, instr_out, pc_out} = '0;
    {rs1_out, rs2_out, rs3_out} = '0;
  end
  // Loop select rides in the word as software put it
  task automatic send(input logic [31:0] i, input logic [31:0] p);
    {instr_valid_out, instr_out, pc_out} = {1'b1, i, p};
    {rs1_out, rs2_out, rs3_out} = {regs[i[19:15]], regs[i[24:20]], regs[i[11:7]]};
  endtask
  // Idle lines flip so a decoder leaning on stale values shows up
  task automatic idle();
    {instr_valid_out, instr_out, pc_out} = {1'b0, ~instr_out, ~pc_out};
    {rs1_out, rs2_out, rs3_out} = {~rs1_out, ~rs2_out, ~rs3_out};
  endtask
endmodule

// ===== cmh_decoder_test.sv
// Self-checking bench for the custom memory and loop-setup decoder.
// Assumes the fetch model file is compiled first; event load enabled.
`timescale 1ns/1ps
module cmh_decoder_test;
  import cmh_pkg::*;
  // ==================================================================
  // Signals
  localparam logic [6:0] F7S [16] = '{7'h00, 7'h08, 7'h01, 7'h09, 7'h02, 7'h04, 7'h0C,
    7'h05, 7'h0D, 7'h06, 7'h10, 7'h11, 7'h12, 7'h14, 7'h15, 7'h16};
  logic        ref_clk, rstn;
  logic [31:0] mem_rdata, pc, w, li;
  logic        e_req, e_we, e_sgn, e_bwe, e_rdwe, e_ill, e_slp;
  logic [1:0]  e_size;
  logic [31:0] e_addr, e_wd, e_bwd;
  logic [31:0] e_ls [2], e_le [2], e_lc [2];
  int          fail_count, comparisons;
  wire logic        valid, mem_req, mem_we, mem_signed, event_sleep, rd_we, base_we, illegal;
  wire logic [1:0]  mem_size;
  wire logic [4:0]  rd_addr, base_addr;
  wire logic [31:0] instr, pc_f, rs1, rs2, rs3, mem_addr, mem_wdata, base_wdata, load_ext;
  wire logic [NUM_LOOPS*32-1:0] loop_start, loop_end, loop_count;
  // ==================================================================
  // Instances
  cmh_fetch_model cmh_fetch_model_inst (.instr_valid_out(valid), .instr_out(instr),
    .pc_out(pc_f), .rs1_out(rs1), .rs2_out(rs2), .rs3_out(rs3));
  cmh_decoder #(.CUSTOM_EXT_ENABLE_PARAM(1'b1), .CLUSTER_SUPPORT_PARAM(1'b1)) cmh_decoder_inst (
    .ref_clk_in(ref_clk), .rstn_in(rstn), .instr_valid_in(valid), .instr_in(instr),
    .pc_in(pc_f), .rs1_data_in(rs1), .rs2_data_in(rs2), .rs3_data_in(rs3),
    .mem_rdata_in(mem_rdata), .mem_req_out(mem_req), .mem_we_out(mem_we),
    .mem_size_out(mem_size), .mem_signed_out(mem_signed), .mem_addr_out(mem_addr),
    .mem_wdata_out(mem_wdata), .event_sleep_out(event_sleep), .rd_we_out(rd_we),
    .rd_addr_out(rd_addr), .base_we_out(base_we), .base_addr_out(base_addr),
    .base_wdata_out(base_wdata), .load_ext_out(load_ext), .illegal_out(illegal),
    .loop_start_out(loop_start), .loop_end_out(loop_end), .loop_count_out(loop_count));
  // ==================================================================
  // Reference decode
  function automatic logic [31:0] ext(input logic [31:0] d, input logic [1:0] s, input logic g);
    if (s == SIZE_BYTE) return g ? {{24{d[7]}}, d[7:0]} : {24'h0, d[7:0]};
    if (s == SIZE_HALF) return g ? {{16{d[15]}}, d[15:0]} : {16'h0, d[15:0]};
    return d;
  endfunction
  function automatic logic [31:0] mk(input logic [6:0] op, input logic [2:0] f3);
    logic [31:0] r;
    r = $urandom;
    return {r[31:15], f3, r[11:7], op};
  endfunction
  task automatic predict(input logic [31:0] i, input bit v);
    logic [31:0] a, b, c, ul;
    logic [6:0]  f7;
    logic [2:0]  f3;
    logic [3:0]  f4;
    logic        l;
    a = cmh_fetch_model_inst.regs[i[19:15]];
    b = cmh_fetch_model_inst.regs[i[24:20]];
    c = cmh_fetch_model_inst.regs[i[11:7]];
    {f7, f3, f4, l, ul, li} = {i[31:25], i[14:12], i[11:7], 20'h0, i[31:20], i};
    {e_req, e_we, e_sgn, e_bwe, e_rdwe, e_ill, e_slp} = '0;
    {e_size, e_addr, e_wd, e_bwd} = {SIZE_WORD, a, b, a};
    if (!v) return;
    if (i[6:0] == OPC_LOAD_PI) begin
      e_ill = f3 inside {3'h6, 3'h7};
      {e_req, e_rdwe, e_bwe, e_slp} = {!e_ill, !e_ill, !e_ill && f3 != F3_EVT, f3 == F3_EVT};
      e_size = (f3 == F3_EVT) ? SIZE_WORD : f3[1:0];
      e_sgn = !f3[2] && f3[1:0] != SIZE_WORD;
      if (f3 == F3_EVT) e_addr = a + {{20{i[31]}}, i[31:20]};
      else e_bwd = a + {{20{i[31]}}, i[31:20]};
    end else if (i[6:0] == OPC_CUSTOM) begin
      if (f3 < F3_REG) begin
        {e_req, e_we, e_bwe, e_size} = {3'b111, f3[1:0]};
        e_bwd = a + {{20{i[31]}}, i[31:25], i[11:7]};
      end else if (f3 == F3_REG && f7 inside {F7S}) begin
        {e_req, e_we, e_rdwe, e_bwe, e_size} = {1'b1, f7[4], !f7[4], !f7[2], f7[1:0]};
        e_sgn = !f7[3] && f7[1:0] != SIZE_WORD;
        if (f7[2]) e_addr = a + (f7[4] ? c : b);
        else e_bwd = a + (f7[4] ? c : b);
      end else if (f3 == F3_HWLP) begin
        e_ill = f4[3] || (f4 < 6 && (f4[0] ? i[31:20] != 0 : i[19:15] != 0));
        if (!e_ill) case (f4[2:0])
          3'h0: e_ls[l] = pc + (ul << 2);
          3'h1: e_ls[l] = a;
          3'h2: e_le[l] = pc + (ul << 2);
          3'h3: e_le[l] = a;
          3'h4: e_lc[l] = ul;
          3'h5: e_lc[l] = a;
          default: begin
            e_ls[l] = pc + 32'h0000_0004;
            e_le[l] = pc + ((f4[0] ? ul : {27'h0, i[19:15]}) << 2);
            e_lc[l] = f4[0] ? a : ul;
          end
        endcase
      end else if (f3 != F3_REG) e_ill = 1'b1;
    end
  endtask
  // ==================================================================
  // Checking and driving
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask
  task automatic verify();
    chk("flags", 32'({e_req, e_we, e_bwe, e_rdwe, e_ill, e_slp}),
      32'({mem_req, mem_we, base_we, rd_we, illegal, event_sleep}));
    if (e_req) chk("size", 32'(e_size), 32'(mem_size));
    if (e_req) chk("addr", e_addr, mem_addr);
    if (e_we) chk("wdata", e_wd, mem_wdata);
    if (e_rdwe) chk("rd_addr", 32'(li[11:7]), 32'(rd_addr));
    if (e_rdwe && e_size != SIZE_WORD) chk("signed", 32'(e_sgn), 32'(mem_signed));
    if (e_rdwe) chk("load_ext", ext(mem_rdata, e_size, e_sgn), load_ext);
    if (e_bwe) chk("base_addr", 32'(li[19:15]), 32'(base_addr));
    if (e_bwe) chk("base_wdata", e_bwd, base_wdata);
    for (int k = 0; k < NUM_LOOPS; k++) begin
      chk("loop_start", e_ls[k], loop_start[k*32 +: 32]);
      chk("loop_end", e_le[k], loop_end[k*32 +: 32]);
      chk("loop_count", e_lc[k], loop_count[k*32 +: 32]);
    end
  endtask
  // Checks the word taken one edge ago, then offers the next back to back
  task automatic run(input logic [31:0] i, input bit v);
    @(negedge ref_clk);
    mem_rdata = $urandom;
    #1;
    verify();
    if (v) cmh_fetch_model_inst.send(i, pc);
    else cmh_fetch_model_inst.idle();
    predict(i, v);
    if (v) pc += 32'h0000_0004;
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ==================================================================
  // Clock, watchdog and tests
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    fail_count++;
    results();
  end
  initial begin
    {rstn, mem_rdata, pc, fail_count, comparisons} = '0;
    {e_req, e_we, e_sgn, e_bwe, e_rdwe, e_ill, e_slp} = '0;
    {e_ls[0], e_ls[1], e_le[0], e_le[1], e_lc[0], e_lc[1]} = '0;
    void'($urandom(32'h3DFC));
    foreach (cmh_fetch_model_inst.regs[k]) cmh_fetch_model_inst.regs[k] = k ? $urandom : 0;
    pc = $urandom & 32'hFFFF_FFFC;
    repeat (20) @(negedge ref_clk);
    rstn = 1'b1;
    for (int k = 0; k < 8; k++) begin
      run(mk(OPC_LOAD_PI, 3'(k)), 1'b1);
      run(mk(OPC_CUSTOM, 3'(k)), 1'b1);
    end
    foreach (F7S[k]) begin
      w = mk(OPC_CUSTOM, F3_REG);
      run({F7S[k], w[24:0]}, 1'b1);
    end
    $display("test memory_forms done, mismatches %0d", fail_count);
    // Loop ops on both loops, then a long form with a stray upper bit
    for (int k = 0; k < 17; k++) begin
      w = mk(OPC_CUSTOM, F3_HWLP);
      w[11:7] = (k == 16) ? 5'h02 : 5'(k);
      if (k < 12 && k[1]) w[31:20] = '0;
      else if (k < 12) w[19:15] = '0;
      if (k == 16) w[31:20] = 12'h001;
      run(w, 1'b1);
    end
    $display("test loop_setup done, mismatches %0d", fail_count);
    for (int k = 0; k < 600; k++) begin
      w = mk($urandom_range(1, 0) ? OPC_LOAD_PI : OPC_CUSTOM, 3'($urandom));
      if ($urandom_range(2, 0) == 0) w[31:25] = F7S[$urandom_range(15, 0)];
      if (k % 50 == 0) w[6:0] = 7'h33;
      run(w, $urandom_range(4, 0) != 0);
    end
    run(32'h0, 1'b0);
    $display("test random_mix done, mismatches %0d", fail_count);
    results();
  end
endmodule
